//--- verilog/inpos_pkg.sv
package inpos_pkg;
    // ==========================================
    // Register map (word aligned byte addresses)
    localparam logic [7:0]  ADDR_INPOS_RANGE = 8'h00;
    localparam logic [7:0]  ADDR_SPEED_WIDTH = 8'h04;
    localparam logic [7:0]  ADDR_OUT_SELECT  = 8'h08;
    localparam logic [7:0]  ADDR_CONTROL     = 8'h0c;
    localparam logic [7:0]  ADDR_STATUS      = 8'h10;
    localparam logic [7:0]  ADDR_ERROR       = 8'h14;

    // ==========================================
    // Setting limits and reset values
    localparam logic [7:0]  INPOS_RANGE_MAX  = 8'hfa;
    localparam logic [7:0]  INPOS_RANGE_RST  = 8'h01;
    localparam logic [7:0]  SPEED_WIDTH_MAX  = 8'h64;
    localparam logic [7:0]  SPEED_WIDTH_RST  = 8'h0a;
    localparam logic [9:0]  OUT_SEL_MIN      = 10'h06e;
    localparam logic [9:0]  OUT_SEL_MAX      = 10'h29a;
    localparam logic [9:0]  OUT_SEL_RST      = 10'h0d2;
    localparam logic [3:0]  DIGIT_MAX        = 4'h6;
    localparam logic [3:0]  DIGIT_TEN        = 4'ha;

    // ==========================================
    // Widths and modes
    localparam int          ERR_W            = 24;
    localparam int          SPD_W            = 16;
    localparam logic [1:0]  MODE_SPEED       = 2'h0;
    localparam logic [1:0]  MODE_POSITION    = 2'h1;
    localparam logic [1:0]  MODE_TORQUE      = 2'h2;

    // Digit function codes
    localparam logic [3:0]  FN_MATCH         = 4'h0;
    localparam logic [3:0]  FN_RUNNING       = 4'h1;
    localparam logic [3:0]  FN_READY         = 4'h2;
    localparam logic [3:0]  FN_TLIMIT        = 4'h3;
    localparam logic [3:0]  FN_BRAKE         = 4'h4;
    localparam logic [3:0]  FN_OL_WARN       = 4'h5;
    localparam logic [3:0]  FN_OL_ALARM      = 4'h6;

    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
endpackage

//--- verilog/inposition_speed_match_outputs.sv
// Contract
// - Position mode asserts in-position while error magnitude is below the range.
// - In-position range accepts 0 to 250, reset value 1.
// - Torque mode holds in-position asserted regardless of error.
// - Speed mode puts speed-match on the first output pair instead.
// - Speed-match asserts when speed difference magnitude does not exceed width.
// - Speed-match width accepts 0 to 100, reset value 10.
// - Torque mode holds speed-match asserted.
// - Output select is 110 to 666, reset 210; others rejected.
// - Ones digit picks pair one, tens pair two, hundreds pair three.
// - Codes 0..6 map to functions; code 0 only on pair one.
// - Outputs active low: asserted drives line low.
// - Range only affects in-position output, not the servo loop.
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
module inposition_speed_match_outputs
    import inpos_pkg::*;
(
    input  wire logic                         i_clock,
    input  wire logic                         i_arst_n,
    input  wire logic                         i_hsel,
    input  wire logic [7:0]                   i_haddr,
    input  wire logic [1:0]                   i_htrans,
    input  wire logic                         i_hwrite,
    input  wire logic [2:0]                   i_hsize,
    input  wire logic [31:0]                  i_hwdata,
    input  wire logic                         i_hready,
    output logic      [31:0]                  o_hrdata,
    output logic                              o_hreadyout,
    output logic                              o_hresp,
    input  wire logic [1:0]                   i_control_mode,
    input  wire logic signed [inpos_pkg::ERR_W-1:0] i_position_error,
    input  wire logic signed [inpos_pkg::SPD_W-1:0] i_speed_reference,
    input  wire logic signed [inpos_pkg::SPD_W-1:0] i_motor_speed,
    input  wire logic                         i_motor_running,
    input  wire logic                         i_servo_ready,
    input  wire logic                         i_torque_limit_detect,
    input  wire logic                         i_brake_control,
    input  wire logic                         i_overload_warning,
    input  wire logic                         i_overload_alarm,
    output logic                              o_pair1_n,
    output logic                              o_pair2_n,
    output logic                              o_pair3_n
);
    import inpos_pkg::*;

    // ==========================================
    // State
    typedef struct packed {
        logic [7:0]       range_reg;
        logic [7:0]       width_reg;
        logic [9:0]       sel_reg;
        logic [3:0]       err_reg;
        logic             wr_pend;
        logic             rd_pend;
        logic [7:0]       addr;
        logic [31:0]      rdata;
        logic [1:0]       mode_s1;
        logic [1:0]       mode_s2;
        logic [ERR_W-1:0] perr_s1;
        logic [ERR_W-1:0] perr_s2;
        logic [SPD_W-1:0] sref_s1;
        logic [SPD_W-1:0] sref_s2;
        logic [SPD_W-1:0] spd_s1;
        logic [SPD_W-1:0] spd_s2;
        logic [5:0]       fl_s1;
        logic [5:0]       fl_s2;
        logic             in_position_out;
        logic             speed_match_out;
        logic [2:0]       pair_n;
        logic             readyout;
        logic             resp;
        logic [1:0]       mode_cmp;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Pins come out of reset deasserted (high), settings at their defaults
    localparam state_t STATE_RST = '{
        range_reg:       INPOS_RANGE_RST,
        width_reg:       SPEED_WIDTH_RST,
        sel_reg:         OUT_SEL_RST,
        err_reg:         '0,
        wr_pend:         1'b0,
        rd_pend:         1'b0,
        addr:            '0,
        rdata:           '0,
        mode_s1:         '0,
        mode_s2:         '0,
        perr_s1:         '0,
        perr_s2:         '0,
        sref_s1:         '0,
        sref_s2:         '0,
        spd_s1:          '0,
        spd_s2:          '0,
        fl_s1:           '0,
        fl_s2:           '0,
        in_position_out: 1'b0,
        speed_match_out: 1'b0,
        pair_n:          '1,
        readyout:        1'b1,
        resp:            1'b0,
        mode_cmp:        '0
    };

    // ==========================================
    // Helpers
    function automatic logic [ERR_W-1:0] mag_err(input logic [ERR_W-1:0] v);
        mag_err = v[ERR_W-1] ? ERR_W'(-v) : v;
    endfunction

    function automatic logic [SPD_W:0] mag_diff(input logic [SPD_W-1:0] a,
                                               input logic [SPD_W-1:0] b);
        logic signed [SPD_W:0] d;
        d = $signed({a[SPD_W-1], a}) - $signed({b[SPD_W-1], b});
        mag_diff = d[SPD_W] ? (SPD_W+1)'(-d) : d;
    endfunction

    // Range and width settings share one acceptance test
    function automatic logic fits_byte(input logic [31:0] v, input logic [7:0] lim);
        fits_byte = v[31:8] == '0 && v[7:0] <= lim;
    endfunction

    // Strict compare: a zero range never asserts outside torque mode
    function automatic logic pos_hit(input logic [ERR_W-1:0] e, input logic [7:0] lim);
        pos_hit = mag_err(e) < ERR_W'(lim);
    endfunction

    // Inclusive band, symmetric about the reference
    function automatic logic speed_hit(input logic [SPD_W-1:0] a, input logic [SPD_W-1:0] b,
                                       input logic [7:0] lim);
        speed_hit = mag_diff(a, b) <= (SPD_W+1)'(lim);
    endfunction

    function automatic logic [3:0] digit(input logic [9:0] v, input int pos);
        logic [9:0] q;
        q = v;
        for (int k = 0; k < 2; k++) begin
            if (k < pos) begin
                q = q / 10'(DIGIT_TEN);
            end
        end
        digit = 4'(q % 10'(DIGIT_TEN));
    endfunction

    // Three digits, each a code up to six; the match code only on pair one
    function automatic logic sel_valid(input logic [31:0] v);
        logic [3:0] d0;
        logic [3:0] d1;
        logic [3:0] d2;
        d0 = digit(v[9:0], 0);
        d1 = digit(v[9:0], 1);
        d2 = digit(v[9:0], 2);
        sel_valid = v[31:10] == '0 && v[9:0] >= OUT_SEL_MIN && v[9:0] <= OUT_SEL_MAX
                    && d0 <= DIGIT_MAX && d1 <= DIGIT_MAX && d2 <= DIGIT_MAX
                    && d1 != FN_MATCH && d2 != FN_MATCH;
    endfunction

    // Unmapped offsets read as zero
    function automatic logic [31:0] read_word(input logic [7:0] a, input state_t s);
        case (a)
            ADDR_INPOS_RANGE: read_word = {24'h0, s.range_reg};
            ADDR_SPEED_WIDTH: read_word = {24'h0, s.width_reg};
            ADDR_OUT_SELECT:  read_word = {22'h0, s.sel_reg};
            ADDR_CONTROL:     read_word = {30'h0, s.mode_s2};
            ADDR_STATUS:      read_word = {29'h0, ~s.pair_n};
            ADDR_ERROR:       read_word = {28'h0, s.err_reg};
            default:          read_word = '0;
        endcase
    endfunction

    // Pair index 0 is the only one allowed the match function
    function automatic logic pick(input logic [3:0] code, input logic [5:0] fl,
                                  input logic match);
        case (code)
            FN_MATCH:    pick = match;
            FN_RUNNING:  pick = fl[0];
            FN_READY:    pick = fl[1];
            FN_TLIMIT:   pick = fl[2];
            FN_BRAKE:    pick = fl[3];
            FN_OL_WARN:  pick = fl[4];
            FN_OL_ALARM: pick = fl[5];
            default:     pick = 1'b0;
        endcase
    endfunction

    // ==========================================
    // Next state
    logic        wr_take;
    logic        rd_take;
    logic [31:0] wd;
    logic        sel_ok;
    logic        match;

    always_comb begin
        state_next = state_reg;
        wd = i_hwdata;
        wr_take = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ && i_hwrite;
        rd_take = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ && !i_hwrite;

        // Input synchronisers
        state_next.mode_s1 = i_control_mode;
        state_next.mode_s2 = state_reg.mode_s1;
        state_next.perr_s1 = i_position_error;
        state_next.perr_s2 = state_reg.perr_s1;
        state_next.sref_s1 = i_speed_reference;
        state_next.sref_s2 = state_reg.sref_s1;
        state_next.spd_s1  = i_motor_speed;
        state_next.spd_s2  = state_reg.spd_s1;
        state_next.fl_s1   = {i_overload_alarm, i_overload_warning, i_brake_control,
                              i_torque_limit_detect, i_servo_ready, i_motor_running};
        state_next.fl_s2   = state_reg.fl_s1;
        // Mode as the compare stage saw it, so pair one never mixes two modes
        state_next.mode_cmp = state_reg.mode_s2;

        // Bus write data phase: out-of-range settings rejected, old value kept
        sel_ok = sel_valid(wd);
        if (state_reg.wr_pend) begin
            case (state_reg.addr)
                ADDR_INPOS_RANGE: begin
                    if (fits_byte(wd, INPOS_RANGE_MAX)) begin
                        state_next.range_reg = wd[7:0];
                    end else begin
                        state_next.err_reg[0] = 1'b1;
                    end
                end
                ADDR_SPEED_WIDTH: begin
                    if (fits_byte(wd, SPEED_WIDTH_MAX)) begin
                        state_next.width_reg = wd[7:0];
                    end else begin
                        state_next.err_reg[1] = 1'b1;
                    end
                end
                ADDR_OUT_SELECT: begin
                    if (sel_ok) begin
                        state_next.sel_reg = wd[9:0];
                    end else begin
                        state_next.err_reg[2] = 1'b1;
                    end
                end
                ADDR_ERROR: begin
                    // Write one to clear
                    state_next.err_reg = state_reg.err_reg & ~wd[3:0];
                end
                default: begin
                end
            endcase
        end

        // Address phase capture
        state_next.wr_pend = wr_take;
        state_next.rd_pend = rd_take;
        if (wr_take || rd_take) begin
            state_next.addr = i_haddr;
        end
        state_next.rdata = '0;
        if (rd_take) begin
            state_next.rdata = read_word(i_haddr, state_reg);
        end

        // Comparisons on magnitude, every cycle
        state_next.in_position_out = (state_reg.mode_s2 == MODE_TORQUE)
            || (state_reg.mode_s2 == MODE_POSITION
                && pos_hit(state_reg.perr_s2, state_reg.range_reg));
        state_next.speed_match_out = (state_reg.mode_s2 == MODE_TORQUE)
            || (state_reg.mode_s2 == MODE_SPEED
                && speed_hit(state_reg.sref_s2, state_reg.spd_s2,
                             state_reg.width_reg));

        // Range feeds nothing but the in-position flag
        match = (state_reg.mode_cmp == MODE_SPEED) ? state_reg.speed_match_out
                                                  : state_reg.in_position_out;
        state_next.pair_n[0] = ~pick(digit(state_reg.sel_reg, 0), state_reg.fl_s2,
                                     match);
        state_next.pair_n[1] = ~pick(digit(state_reg.sel_reg, 1), state_reg.fl_s2,
                                     1'b0);
        state_next.pair_n[2] = ~pick(digit(state_reg.sel_reg, 2), state_reg.fl_s2,
                                     1'b0);

        // Zero wait states and always OKAY, still driven from flops
        state_next.readyout = 1'b1;
        state_next.resp     = 1'b0;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================
    // Outputs
    always_comb begin
        o_hrdata    = state_reg.rdata;
        o_hreadyout = state_reg.readyout;
        o_hresp     = state_reg.resp;
        o_pair1_n   = state_reg.pair_n[0];
        o_pair2_n   = state_reg.pair_n[1];
        o_pair3_n   = state_reg.pair_n[2];
    end
endmodule

//--- test/isp_checker_properties.sv
`timescale 1ns/1ps
module isp_checker
    import inpos_pkg::*;
(
    input  wire logic                          i_clock,
    input  wire logic                          i_arst_n,
    input  wire logic [1:0]                    i_control_mode,
    input  wire logic signed [ERR_W-1:0]       i_position_error,
    input  wire logic signed [SPD_W-1:0]       i_speed_reference,
    input  wire logic signed [SPD_W-1:0]       i_motor_speed,
    input  wire logic                          i_motor_running,
    input  wire logic                          i_servo_ready,
    input  wire logic                          i_torque_limit_detect,
    input  wire logic                          i_brake_control,
    input  wire logic                          i_overload_warning,
    input  wire logic                          i_overload_alarm,
    input  wire logic                          o_hreadyout,
    input  wire logic                          o_hresp,
    input  wire logic                          o_pair1_n,
    input  wire logic                          o_pair2_n,
    input  wire logic                          o_pair3_n
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    // ==========================================
    // Conditions that hold whatever the settings are
    logic signed [16:0] sd;
    logic [2:0]         pins;
    logic               far_s, far_p, fl_hi, fl_lo;
    assign sd    = i_speed_reference - i_motor_speed;
    assign far_s = (sd > 17'sh64) || (sd < -17'sh64);
    assign far_p = (i_position_error > 24'shfa) || (i_position_error < -24'shfa);
    assign fl_hi = &{i_motor_running, i_servo_ready, i_torque_limit_detect,
                     i_brake_control, i_overload_warning, i_overload_alarm};
    assign fl_lo = ~|{i_motor_running, i_servo_ready, i_torque_limit_detect,
                      i_brake_control, i_overload_warning, i_overload_alarm};
    assign pins  = {o_pair3_n, o_pair2_n, o_pair1_n};
    // ==========================================
    // Assertions
    property p_torque_on;
        (i_control_mode == MODE_TORQUE && fl_hi) [*4] |=> pins == 3'h0;
    endproperty
    a_torque_on: assert property (p_torque_on) else $error("torque pins not low");
    property p_none_off;
        (i_control_mode == 2'h3 && fl_lo) [*4] |=> pins == 3'h7;
    endproperty
    a_none_off: assert property (p_none_off) else $error("idle mode pins not high");
    property p_speed_far;
        (i_control_mode == MODE_SPEED && fl_lo && far_s) [*4] |=> pins == 3'h7;
    endproperty
    a_speed_far: assert property (p_speed_far) else $error("speed match too wide");
    property p_pos_far;
        (i_control_mode == MODE_POSITION && fl_lo && far_p) [*4] |=> pins == 3'h7;
    endproperty
    a_pos_far: assert property (p_pos_far) else $error("in position too wide");
    // Flags reach the pins in three edges
    property p_upper_on;
        fl_hi [*3] |=> !o_pair2_n && !o_pair3_n;
    endproperty
    a_upper_on: assert property (p_upper_on) else $error("upper pairs not low");
    property p_upper_off;
        fl_lo [*3] |=> o_pair2_n && o_pair3_n;
    endproperty
    a_upper_off: assert property (p_upper_off) else $error("upper pairs not high");
    property p_reset_pins;
        $rose(i_arst_n) |-> pins == 3'h7;
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pins low after reset");
    property p_okay;
        o_hreadyout && !o_hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("bus answer not okay");
    c_torque: cover property ((i_control_mode == MODE_TORQUE && fl_hi) [*4]);
    c_speed_far: cover property ((i_control_mode == MODE_SPEED && fl_lo && far_s) [*4]);
    c_pos_far: cover property ((i_control_mode == MODE_POSITION && fl_lo && far_p) [*4]);
endmodule

bind inposition_speed_match_outputs isp_checker i_chk (.*);

//--- test/host_interlock_model.sv
`timescale 1ns/1ps
module host_interlock_model (
    input  wire logic i_clock,
    input  wire logic i_arst_n,
    input  wire logic i_pair1_n,
    output logic      o_move_done
);
    // Move counts as finished only once the low level is seen
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) o_move_done <= 1'b0;
        else o_move_done <= !i_pair1_n;
    end
endmodule

//--- test/inposition_speed_match_outputs_tb_top.sv
`timescale 1ns/1ps
module inposition_speed_match_outputs_tb_top;
    import inpos_pkg::*;
    logic i_clock = 0, i_arst_n = 0, i_hsel = 0, i_hwrite = 0;
    logic i_hready;
    logic [7:0] i_haddr = 8'h0;
    logic [1:0] i_htrans = 2'h0, i_control_mode = 2'h3;
    logic [2:0] i_hsize = 3'h2;
    logic [31:0] i_hwdata = 32'h0, o_hrdata;
    logic signed [23:0] i_position_error = 24'h0;
    logic signed [15:0] i_speed_reference = 16'h0, i_motor_speed = 16'h0;
    logic i_motor_running = 0, i_servo_ready = 0, i_torque_limit_detect = 0;
    logic i_brake_control = 0, i_overload_warning = 0, i_overload_alarm = 0;
    logic o_hreadyout, o_hresp, o_pair1_n, o_pair2_n, o_pair3_n, move_done;
    logic rd_ph = 0, pstb = 0;
    logic [31:0] rq[$];
    logic [2:0] pq[$];
    int fail_count = 0, check_count = 0, rr, ww, r;
    logic [5:0] f;
    logic [2:0] pexp;
    logic [7:0] ta[10] = '{8'h00, 8'h04, 8'h08, 8'h08, 8'h08, 8'h08, 8'h00, 8'h04, 8'h08, 8'h08};
    logic [31:0] tv[10] = '{32'hfb, 32'h65, 32'h6d, 32'h29b, 32'h259, 32'hd9, 32'hfa, 32'h64,
                            32'h29a, 32'h6e};
    logic [31:0] te[10] = '{32'h1, 32'ha, 32'hd2, 32'hd2, 32'hd2, 32'hd2, 32'hfa, 32'h64,
                            32'h29a, 32'h6e};
    inposition_speed_match_outputs i_dut (.*);
    assign i_hready = o_hreadyout;
    host_interlock_model i_host (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_pair1_n(o_pair1_n),
                                 .o_move_done(move_done));
    always #2.5 i_clock = ~i_clock;
    // ==========================================
    // Reporting
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_pins(input logic [3:0] e, input logic [3:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value pins_done expected %h seen %h", e, g);
        end
    endtask
    // ==========================================
    // Drivers
    task automatic wait_rdy();
        int n = 0;
        @(posedge i_clock);
        while (o_hreadyout !== 1'b1 && n < 20) begin
            @(posedge i_clock);
            n++;
        end
        if (n >= 20) begin
            fail_count++;
            print_verdict();
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, e);
        i_hsel <= 1'b1;
        i_htrans <= HTRANS_NONSEQ;
        i_haddr <= a;
        i_hwrite <= w;
        wait_rdy();
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= d;
        rd_ph <= !w;
        if (!w) rq.push_back(e);
        wait_rdy();
        rd_ph <= 1'b0;
    endtask
    // Holds inputs past the four-edge pin latency plus settings lag
    task automatic pins(input logic [1:0] m, input int e, rf, s, input logic [5:0] fl,
                        input logic [2:0] x);
        i_control_mode <= m;
        i_position_error <= e[23:0];
        i_speed_reference <= rf[15:0];
        i_motor_speed <= s[15:0];
        {i_overload_alarm, i_overload_warning, i_brake_control, i_torque_limit_detect,
         i_servo_ready, i_motor_running} <= fl;
        repeat (6) @(posedge i_clock);
        pq.push_back(x);
        pstb <= 1'b1;
        @(posedge i_clock);
        pstb <= 1'b0;
    endtask
    // ==========================================
    // Monitor
    always @(posedge i_clock) begin
        if (rd_ph && rq.size() > 0) chk("hrdata", rq.pop_front(), o_hrdata);
        if (pstb && pq.size() > 0) begin
            pexp = pq.pop_front();
            chk_pins({~pexp[0], pexp},
                     {move_done, o_pair3_n, o_pair2_n, o_pair1_n});
        end
    end
    initial begin
        #400us;
        fail_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(99577));
        repeat (10) @(posedge i_clock);
        i_arst_n <= 1'b1;
        @(posedge i_clock);
        ahb(1'b0, ADDR_INPOS_RANGE, 32'h0, 32'h1);
        ahb(1'b0, ADDR_SPEED_WIDTH, 32'h0, 32'ha);
        ahb(1'b0, ADDR_OUT_SELECT, 32'h0, 32'hd2);
        for (int i = 0; i < 10; i++) begin
            ahb(1'b1, ta[i], tv[i], 32'h0);
            ahb(1'b0, ta[i], 32'h0, te[i]);
        end
        ahb(1'b0, ADDR_ERROR, 32'h0, 32'h7);
        ahb(1'b1, ADDR_ERROR, 32'h7, 32'h0);
        ahb(1'b0, ADDR_ERROR, 32'h0, 32'h0);
        ahb(1'b1, 8'h40, 32'h5, 32'h0);
        ahb(1'b0, 8'h40, 32'h0, 32'h0);
        rr = 1 + $urandom % 250;
        ww = $urandom % 101;
        ahb(1'b1, ADDR_INPOS_RANGE, rr, 32'h0);
        ahb(1'b1, ADDR_SPEED_WIDTH, ww, 32'h0);
        ahb(1'b1, ADDR_OUT_SELECT, 32'hd2, 32'h0);
        for (int k = 0; k < 4; k++) begin
            f = $urandom;
            pins(MODE_POSITION, (k[0] ? -1 : 1) * (rr - 1 + k[1]), 0, 0, f,
                 {~f[1], ~f[0], k[1]});
            r = $urandom % 2000 - 1000;
            pins(MODE_SPEED, 0, r, r + (k[0] ? -1 : 1) * (ww + k[1]), f,
                 {~f[1], ~f[0], k[1]});
        end
        pins(MODE_TORQUE, 8000000, 1000, -1000, 6'h3f, 3'h0);
        ahb(1'b0, ADDR_STATUS, 32'h0, 32'h7);
        ahb(1'b0, ADDR_CONTROL, 32'h0, {30'h0, MODE_TORQUE});
        pins(2'h3, 0, 0, 0, 6'h0, 3'h7);
        pins(MODE_SPEED, 0, 500, -500, 6'h0, 3'h7);
        pins(MODE_POSITION, -1000, 0, 0, 6'h0, 3'h7);
        ahb(1'b1, ADDR_INPOS_RANGE, 32'h0, 32'h0);
        pins(MODE_POSITION, 0, 0, 0, 6'h3f, 3'h1);
        for (int c = 1; c < 7; c++) begin
            ahb(1'b1, ADDR_OUT_SELECT, c * 111, 32'h0);
            f = $urandom;
            pins(2'h3, 0, 0, 0, f, {3{~f[c-1]}});
        end
        print_verdict();
    end
endmodule
